// File: src/port_zero_io.sv
// What this block does
// - eight bits, each usable as input or output
// - output latch holds last written value
// - pin reads return live level, unlatched
// - pins sampled in the read setup cycle
// - pin drive updates one clock after latch write edge
// - reset sets latch ones, drive type zeros
// - drive select zero open-drain, one push-pull
// - latch register reads stored latch contents
// - pin level register read only, writes ignored
`default_nettype none
module port_zero_io
  import port_zero_pkg::*;
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_WIDTH-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // port pins
  input wire logic [PORT_WIDTH-1:0] i_pin,
  output logic [PORT_WIDTH-1:0] o_pin,
  output logic [PORT_WIDTH-1:0] o_pin_oe
);

  logic [PORT_WIDTH-1:0] output_latch_ff;
  logic [PORT_WIDTH-1:0] drive_type_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic [PORT_WIDTH-1:0] pin_ff;
  logic [PORT_WIDTH-1:0] pin_oe_ff;
  logic [PORT_WIDTH-1:0] nxt_oe;
  logic setup;
  logic wr_latch;
  logic wr_drive;
  logic wr_pins;
  logic access;
  logic rd_req;
  logic mapped;

  function automatic logic hit_latch(input logic [ADDR_WIDTH-1:0] a);
    hit_latch = (a == ADDR_OUTPUT_LATCH);
  endfunction : hit_latch

  function automatic logic hit_drive(input logic [ADDR_WIDTH-1:0] a);
    hit_drive = (a == ADDR_DRIVE_TYPE);
  endfunction : hit_drive

  function automatic logic hit_pins(input logic [ADDR_WIDTH-1:0] a);
    hit_pins = (a == ADDR_PIN_LEVEL);
  endfunction : hit_pins

  function automatic logic is_mapped(input logic [ADDR_WIDTH-1:0] a);
    is_mapped = hit_latch(a) || hit_drive(a) || hit_pins(a);
  endfunction : is_mapped

  // answer with no wait cycle: ready in the first access cycle
  assign setup = i_psel && !i_penable;
  assign access = i_psel && i_penable;
  assign rd_req = setup && !i_pwrite;
  assign mapped = is_mapped(i_paddr);
  assign wr_latch = setup && i_pwrite && i_pstrb[0] && hit_latch(i_paddr);
  assign wr_drive = setup && i_pwrite && i_pstrb[0] && hit_drive(i_paddr);
  assign wr_pins = setup && i_pwrite && hit_pins(i_paddr);

  // output latch
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      output_latch_ff <= RST_OUTPUT_LATCH;
    end else if (wr_latch) begin
      output_latch_ff <= i_pwdata[PORT_WIDTH-1:0];
    end
  end

  // drive type select
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_type_ff <= RST_DRIVE_TYPE;
    end else if (wr_drive) begin
      drive_type_ff <= i_pwdata[PORT_WIDTH-1:0];
    end
  end

  // apb response
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      if (setup && !i_pwrite) begin
        if (i_paddr == ADDR_OUTPUT_LATCH) begin
          prdata_ff <= {24'h00_0000, output_latch_ff};
        end else if (i_paddr == ADDR_DRIVE_TYPE) begin
          prdata_ff <= {24'h00_0000, drive_type_ff};
        end else if (i_paddr == ADDR_PIN_LEVEL) begin
          prdata_ff <= {24'h00_0000, i_pin};
        end else begin
          prdata_ff <= 32'h0000_0000;
        end
      end else if (!setup) begin
        prdata_ff <= 32'h0000_0000;
      end
    end
  end

  // pin drivers
  always_comb begin
    for (int i = 0; i < PORT_WIDTH; i++) begin
      nxt_oe[i] = drive_type_ff[i] || !output_latch_ff[i];
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_ff <= RST_OUTPUT_LATCH;
      pin_oe_ff <= 8'h00;
    end else begin
      pin_ff <= output_latch_ff;
      pin_oe_ff <= nxt_oe;
    end
  end

  assign o_prdata = prdata_ff;
  assign o_pready = pready_ff;
  assign o_pslverr = pslverr_ff;
  assign o_pin = pin_ff;
  assign o_pin_oe = pin_oe_ff;

  chk_reset_values: assert property (
      @(posedge i_clk)
      $fell(i_rst) |->
      output_latch_ff == RST_OUTPUT_LATCH && drive_type_ff == RST_DRIVE_TYPE)
    else $error("reset values wrong");

  chk_reset_pins: assert property (
      @(posedge i_clk)
      $fell(i_rst) |->
      o_pin == RST_OUTPUT_LATCH && o_pin_oe == '0)
    else $error("pins not released at reset");

  chk_reset_bus: assert property (
      @(posedge i_clk)
      $fell(i_rst) |->
      !o_pready && !o_pslverr && o_prdata == 32'h0000_0000)
    else $error("bus outputs not idle at reset");

  chk_latch_write: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_latch |=>
      output_latch_ff == $past(i_pwdata[PORT_WIDTH-1:0]))
    else $error("latch write lost");

  chk_latch_holds: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !wr_latch |=>
      $stable(output_latch_ff))
    else $error("latch changed without write");

  chk_strobe_gate: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup && i_pwrite && !i_pstrb[0] |=>
      $stable(output_latch_ff) && $stable(drive_type_ff))
    else $error("write without lane zero landed");

  chk_read_no_write: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rd_req |=>
      $stable(output_latch_ff) && $stable(drive_type_ff))
    else $error("read changed a register");

  chk_drive_wr_latch: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_drive |=>
      $stable(output_latch_ff))
    else $error("drive write changed latch");

  chk_drive_write: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_drive |=>
      drive_type_ff == $past(i_pwdata[PORT_WIDTH-1:0]))
    else $error("drive type write lost");

  chk_drive_holds: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !wr_drive |=>
      $stable(drive_type_ff))
    else $error("drive type changed without write");

  chk_latch_wr_drive: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_latch |=>
      $stable(drive_type_ff))
    else $error("latch write changed drive type");

  chk_pin_follows: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_latch |=>
      ##1 o_pin == $past(i_pwdata[PORT_WIDTH-1:0], 2))
    else $error("pin not updated after write");

  chk_pin_value: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=>
      o_pin == $past(output_latch_ff))
    else $error("pin value not latch");

  chk_open_drain: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=>
      o_pin_oe == ($past(drive_type_ff) | ~$past(output_latch_ff)))
    else $error("drive enable wrong");

  chk_push_pull: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=>
      (o_pin_oe & $past(drive_type_ff)) == $past(drive_type_ff))
    else $error("push-pull bit not driven");

  chk_sink_low: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=>
      (~o_pin_oe & ~$past(output_latch_ff)) == '0)
    else $error("low latch bit not driven");

  chk_released_ones: assert property (
      @(posedge i_clk) disable iff (i_rst)
      1'b1 |=>
      (o_pin_oe & ~$past(drive_type_ff) & $past(output_latch_ff)) == '0)
    else $error("open-drain one still driven");

  chk_read_latch: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rd_req && hit_latch(i_paddr) |=>
      o_pready && o_prdata[PORT_WIDTH-1:0] == $past(output_latch_ff))
    else $error("latch read wrong");

  chk_read_drive: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rd_req && hit_drive(i_paddr) |=>
      o_pready && o_prdata[PORT_WIDTH-1:0] == $past(drive_type_ff))
    else $error("drive type read wrong");

  chk_read_pins: assert property (
      @(posedge i_clk) disable iff (i_rst)
      rd_req && hit_pins(i_paddr) |=>
      o_pready && o_prdata[PORT_WIDTH-1:0] == $past(i_pin))
    else $error("pin read wrong");

  chk_read_upper: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_pready |->
      o_prdata[31:PORT_WIDTH] == '0)
    else $error("upper read bits set");

  chk_idle_rdata: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !o_pready |->
      o_prdata == 32'h0000_0000)
    else $error("read data outside answer");

  chk_write_no_data: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup && i_pwrite |=>
      o_prdata == 32'h0000_0000)
    else $error("read data on write");

  chk_pin_level_ro: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_pins |=>
      $stable(output_latch_ff) && $stable(drive_type_ff))
    else $error("pin level write had effect");

  chk_pins_no_err: assert property (
      @(posedge i_clk) disable iff (i_rst)
      wr_pins |=>
      o_pready && !o_pslverr)
    else $error("pin level write flagged");

  chk_ready_pulse: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup |=>
      o_pready)
    else $error("no answer after setup");

  chk_ready_single: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_pready |=>
      !o_pready)
    else $error("answer longer than one cycle");

  chk_no_stray_ready: assert property (
      @(posedge i_clk) disable iff (i_rst)
      !setup |=>
      !o_pready)
    else $error("answer without setup");

  chk_access_ready: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_pready |->
      access)
    else $error("answer outside access phase");

  chk_err_unmapped: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup && !mapped |=>
      o_pslverr)
    else $error("unmapped access not flagged");

  chk_err_mapped: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup && mapped |=>
      !o_pslverr)
    else $error("mapped access flagged");

  chk_err_no_data: assert property (
      @(posedge i_clk) disable iff (i_rst)
      o_pslverr |->
      o_pready && o_prdata == 32'h0000_0000)
    else $error("error answer malformed");

  chk_unmapped_write: assert property (
      @(posedge i_clk) disable iff (i_rst)
      setup && i_pwrite && !mapped |=>
      $stable(output_latch_ff) && $stable(drive_type_ff))
    else $error("unmapped write landed");

endmodule : port_zero_io
`default_nettype wire

// File: src/port_zero_pkg.sv
`default_nettype none
package port_zero_pkg;
  // register indices (printed offsets, not all multiples of four)
  localparam logic [7:0] IDX_OUTPUT_LATCH = 8'h00;
  localparam logic [7:0] IDX_DRIVE_TYPE = 8'h08;
  localparam logic [7:0] IDX_PIN_LEVEL = 8'h0b;
  // byte address is four times the index
  localparam logic [11:0] ADDR_OUTPUT_LATCH = {2'h0, IDX_OUTPUT_LATCH, 2'h0};
  localparam logic [11:0] ADDR_DRIVE_TYPE = {2'h0, IDX_DRIVE_TYPE, 2'h0};
  localparam logic [11:0] ADDR_PIN_LEVEL = {2'h0, IDX_PIN_LEVEL, 2'h0};
  localparam logic [7:0] RST_OUTPUT_LATCH = 8'hff;
  localparam logic [7:0] RST_DRIVE_TYPE = 8'h00;
  localparam int PORT_WIDTH = 8;
  localparam int ADDR_WIDTH = 12;
endpackage : port_zero_pkg
`default_nettype wire

// File: bench/board_model.sv
`default_nettype none
module board_model (
  // port side
  input wire logic [7:0] i_drv,
  input wire logic [7:0] i_oe,
  // external sources
  input wire logic [7:0] i_ext_en,
  input wire logic [7:0] i_ext_val,
  output logic [7:0] o_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // driven bits win, else source, else pull-up
  always_comb o_level = (i_oe & i_drv) | (~i_oe & ((i_ext_en & i_ext_val) | ~i_ext_en));
endmodule : board_model
`default_nettype wire

// File: bench/testbench.sv
`default_nettype none
module testbench import port_zero_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fails++; \
    $display("mismatch %0t got %h exp %h", $time, a, b); end end
  logic i_clk = 0, i_rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r = 32'h6144365e;
  logic [7:0] pin, pdrv, oe, en = 0, v = 0, lat, drv;
  logic [32:0] q[$], e;
  logic [3:0] strb = 4'hf;
  int fails = 0, check_count = 0;
  port_zero_io dut (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pin(pin),
    .o_pin(pdrv), .o_pin_oe(oe));
  board_model board (.i_drv(pdrv), .i_oe(oe), .i_ext_en(en), .i_ext_val(v), .o_level(pin));
  function automatic logic [31:0] nx(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nx
  task automatic finish_test();
    if (fails == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finish_test
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [32:0] x);
    q.push_back(x);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_clk);
    penable <= 1;
    do @(posedge i_clk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge i_clk);
  endtask : xfer
  initial forever #2.5 i_clk = ~i_clk;
  initial begin
    #50000;
    fails++;
    finish_test();
  end
  always @(posedge i_clk) if (pready === 1'b1 && psel && penable) begin
    e = q.pop_front();
    `CHK({pslverr, pwrite ? 32'h0 : prdata}, pwrite ? {e[32], 32'h0} : e)
  end
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    `CHK(oe, 8'h00)
    xfer(0, ADDR_OUTPUT_LATCH, 0, {25'h0, RST_OUTPUT_LATCH});
    xfer(0, ADDR_DRIVE_TYPE, 0, {25'h0, RST_DRIVE_TYPE});
    repeat (6) begin
      r = nx(r);
      lat = r[7:0];
      drv = r[15:8];
      v <= r[23:16];
      en <= r[31:24];
      xfer(1, ADDR_OUTPUT_LATCH, {24'h0, lat}, 0);
      xfer(1, ADDR_DRIVE_TYPE, {24'h0, drv}, 0);
      xfer(0, ADDR_OUTPUT_LATCH, 0, {25'h0, lat});
      xfer(0, ADDR_DRIVE_TYPE, 0, {25'h0, drv});
      `CHK(oe, drv | ~lat)
      `CHK(pdrv & oe, lat & oe)
      xfer(0, ADDR_PIN_LEVEL, 0, {25'h0, (oe & lat) | (~oe & ((en & v) | ~en))});
    end
    xfer(1, ADDR_PIN_LEVEL, 32'h0, 0);
    xfer(0, ADDR_OUTPUT_LATCH, 0, {25'h0, lat});
    strb <= 4'h0;
    xfer(1, ADDR_OUTPUT_LATCH, {24'h0, ~lat}, 0);
    strb <= 4'hf;
    xfer(0, 12'h004, 0, {1'b1, 32'h0});
    xfer(1, 12'h004, 32'hff, {1'b1, 32'h0});
    xfer(0, ADDR_OUTPUT_LATCH, 0, {25'h0, lat});
    i_rst <= 1;
    repeat (2) @(posedge i_clk);
    i_rst <= 0;
    @(posedge i_clk);
    `CHK({pdrv, oe}, {RST_OUTPUT_LATCH, 8'h00})
    xfer(0, ADDR_OUTPUT_LATCH, 0, {25'h0, RST_OUTPUT_LATCH});
    xfer(0, ADDR_DRIVE_TYPE, 0, {25'h0, RST_DRIVE_TYPE});
    finish_test();
  end
endmodule : testbench
`default_nettype wire
